// >>> src/pcd_top.sv
module pcd_top
  import pcd_pkg::*;
(
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  input  wire logic               pcm_bit_clk_in,
  input  wire logic               master_clk_in,
  input  wire logic               tx_frame_sync_in,
  input  wire logic               rx_frame_sync_in,
  input  wire logic               rx_pcm_in,
  input  wire logic [7:0]         tx_pcm_byte_in,
  input  wire logic               ctrl_clock_in,
  input  wire logic               ctrl_cs_n_in,
  input  wire logic               ctrl_data_in,
  input  wire logic [LATCH_N-1:0] latch_pins_in,
  output logic                    tx_pcm_out,
  output logic                    tx_pcm_oe_n_out,
  output logic                    tx_slot_strobe_n_out,
  output logic                    tx_slot_strobe_oe_n_out,
  output logic [7:0]              rx_pcm_byte_out,
  output logic                    rx_pcm_valid_out,
  output logic                    ctrl_data_out,
  output logic                    ctrl_data_oe_n_out,
  output logic [LATCH_N-1:0]      latch_pins_out,
  output logic [LATCH_N-1:0]      latch_pins_oe_n_out,
  output logic                    power_down_out,
  output logic                    a_law_out,
  output logic                    delayed_mode_out,
  output logic [7:0]              tx_gain_out,
  output logic [7:0]              rx_gain_out,
  output logic                    mclk_active_out
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] gain_clamp(input logic [7:0] g);
    gain_clamp = (g > GAIN_MAX) ? GAIN_MAX : g;
  endfunction

  function automatic logic slot_hit(
    input logic              delayed,
    input logic [7:0]        assign_reg,
    input logic [SLOT_W-1:0] cnt
  );
    logic en;
    en = assign_reg[SLOT_EN_BIT];
    if (delayed) begin
      slot_hit = en && (cnt == assign_reg[SLOT_W-1:0]);
    end else begin
      slot_hit = en && (cnt == '0);
    end
  endfunction

  // ==========================================================
  // Pin synchronisers in the core domain
  logic [7:0]         pin_s;
  logic               mclk_s;
  logic               cs_n_s;
  logic               ctrl_clock_s;
  logic               cdin_s;
  logic [LATCH_N-1:0] latch_s;

  pcd_sync #(.W(8)) u_pin_sync (
    .clk_in (core_clk_in),
    .d_in   ({master_clk_in, ctrl_cs_n_in, ctrl_clock_in,
              ctrl_data_in, latch_pins_in}),
    .q_out  (pin_s)
  );

  assign mclk_s  = pin_s[7];
  assign cs_n_s  = pin_s[6];
  assign ctrl_clock_s  = pin_s[5];
  assign cdin_s  = pin_s[4];
  assign latch_s = pin_s[LATCH_N-1:0];

  // ==========================================================
  // Serial control port
  logic       cmd_done;
  logic       wr_done;
  logic [7:0] cmd;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [3:0] addr;

  assign addr = cmd[ADDR_HI:ADDR_LO];

  pcd_ctrl_shift u_ctrl (
    .clk_in       (core_clk_in),
    .rst_in       (rst_in),
    .sclk_in      (ctrl_clock_s),
    .cs_n_in      (cs_n_s),
    .sdi_in       (cdin_s),
    .rd_data_in   (rd_data),
    .cmd_done_out (cmd_done),
    .wr_done_out  (wr_done),
    .cmd_out      (cmd),
    .wr_data_out  (wr_data),
    .sdo_out      (ctrl_data_out),
    .sdo_oe_n_out (ctrl_data_oe_n_out)
  );

  // ==========================================================
  // Programmable registers
  logic [7:0]         ctrl_reg;
  logic [7:0]         tx_gain_reg;
  logic [7:0]         rx_gain_reg;
  logic [7:0]         tx_slot_reg;
  logic [7:0]         rx_slot_reg;
  logic [LATCH_N-1:0] latch_direction_reg;
  logic [LATCH_N-1:0] latch_value_reg;
  logic               power_down;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      power_down <= 1'b1;
    end else if (cmd_done) begin
      power_down <= cmd[CMD_PWR_BIT]; // R19
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_reg            <= RST_CTRL;
      tx_gain_reg         <= RST_GAIN;
      rx_gain_reg         <= RST_GAIN;
      tx_slot_reg         <= RST_SLOT;
      rx_slot_reg         <= RST_SLOT;
      latch_direction_reg <= RST_LDR;
    end else if (wr_done) begin
      if (addr == ADDR_CTRL) begin
        ctrl_reg <= wr_data; // R17
      end else if (addr == ADDR_TXG) begin
        tx_gain_reg <= wr_data; // R16
      end else if (addr == ADDR_RXG) begin
        rx_gain_reg <= wr_data; // R16
      end else if (addr == ADDR_TXTS) begin
        tx_slot_reg <= wr_data; // R15
      end else if (addr == ADDR_RXTS) begin
        rx_slot_reg <= wr_data; // R15
      end else if (addr == ADDR_LDR) begin
        latch_direction_reg <= wr_data[LATCH_N-1:0]; // R12
      end
    end
  end

  // Input pins refresh on each command byte, outputs keep value
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      latch_value_reg <= RST_ILR;
    end else if (wr_done && addr == ADDR_ILR) begin
      latch_value_reg <= wr_data[LATCH_N-1:0]; // R14
    end else if (cmd_done) begin
      latch_value_reg <= (latch_direction_reg & latch_value_reg) |
                         (~latch_direction_reg & latch_s); // R13
    end
  end

  // Read-back selection, undefined codes read as zero
  always_comb begin
    rd_data = 8'h00;
    if (addr == ADDR_CTRL) begin
      rd_data = ctrl_reg;
    end else if (addr == ADDR_TXG) begin
      rd_data = tx_gain_reg;
    end else if (addr == ADDR_RXG) begin
      rd_data = rx_gain_reg;
    end else if (addr == ADDR_TXTS) begin
      rd_data = tx_slot_reg;
    end else if (addr == ADDR_RXTS) begin
      rd_data = rx_slot_reg;
    end else if (addr == ADDR_LDR) begin
      rd_data = {4'h0, latch_direction_reg};
    end else if (addr == ADDR_ILR) begin
      rd_data = {4'h0, latch_value_reg}; // R13
    end
  end

  // ==========================================================
  // Core-side outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      latch_pins_out      <= RST_ILR;
      latch_pins_oe_n_out <= '1;
    end else begin
      latch_pins_out      <= latch_value_reg; // R14
      latch_pins_oe_n_out <= ~latch_direction_reg; // R12
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      power_down_out   <= 1'b1;
      a_law_out        <= 1'b0;
      delayed_mode_out <= 1'b0;
      tx_gain_out      <= RST_GAIN;
      rx_gain_out      <= RST_GAIN;
    end else begin
      power_down_out   <= power_down;
      a_law_out        <= ctrl_reg[CTRL_LAW_BIT]; // R17
      delayed_mode_out <= ctrl_reg[CTRL_DELAY_BIT];
      tx_gain_out      <= gain_clamp(tx_gain_reg); // R16
      rx_gain_out      <= gain_clamp(rx_gain_reg); // R16
    end
  end

  // Master clock activity watchdog
  logic       mclk_d;
  logic [7:0] mclk_cnt;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mclk_d          <= mclk_s;
      mclk_cnt        <= '0;
      mclk_active_out <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
      if (mclk_s != mclk_d) begin
        mclk_cnt <= MCLK_TO_CYC; // R04
      end else if (mclk_cnt != '0) begin
        mclk_cnt <= mclk_cnt - 8'h01;
      end
      mclk_active_out <= (mclk_cnt != '0);
    end
  end

  // ==========================================================
  // Configuration handshake toward the bit clock domain
  logic [CFG_W-1:0] cfg_now;
  logic [CFG_W-1:0] cfg_sent;
  logic             cfg_req;
  logic             cfg_ack_s;

  assign cfg_now = {power_down, ctrl_reg[CTRL_DELAY_BIT],
                    tx_slot_reg[SLOT_EN_BIT:0],
                    rx_slot_reg[SLOT_EN_BIT:0], tx_pcm_byte_in};

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cfg_sent <= {1'b1, 1'b0, 7'h00, 7'h00, 8'h00};
      cfg_req  <= 1'b0;
    end else if (cfg_ack_s == cfg_req && cfg_now != cfg_sent) begin
      cfg_sent <= cfg_now;
      cfg_req  <= ~cfg_req;
    end
  end

  // ==========================================================
  // Bit clock domain
  logic             pcm_rst;
  logic             req_s;
  logic             cfg_ack;
  logic [CFG_W-1:0] pcm_cfg;
  logic             pcm_pd;
  logic             pcm_delayed;
  logic [7:0]       pcm_tx_ts;
  logic [7:0]       pcm_rx_ts;

  pcd_sync #(.W(2)) u_pcm_sync (
    .clk_in (pcm_bit_clk_in),
    .d_in   ({rst_in, cfg_req}),
    .q_out  ({pcm_rst, req_s})
  );

  always_ff @(posedge pcm_bit_clk_in) begin
    if (pcm_rst) begin
      pcm_cfg <= {1'b1, 1'b0, 7'h00, 7'h00, 8'h00};
      cfg_ack <= 1'b0;
    end else if (req_s != cfg_ack) begin
      pcm_cfg <= cfg_sent;
      cfg_ack <= req_s;
    end
  end

  assign pcm_pd      = pcm_cfg[CFG_W-1];
  assign pcm_delayed = pcm_cfg[CFG_W-2];
  assign pcm_tx_ts   = {1'b0, pcm_cfg[21:15]};
  assign pcm_rx_ts   = {1'b0, pcm_cfg[14:8]};

  // Transmit slot timing on rising bit clock
  logic              tx_fs_d;
  logic              tx_run;
  logic [BIT_W-1:0]  tx_bit;
  logic [SLOT_W-1:0] tx_slot;
  logic [7:0]        tx_byte;
  logic              next_tx_run;
  logic [BIT_W-1:0]  next_tx_bit;
  logic [SLOT_W-1:0] next_tx_slot;
  logic              tx_start;
  logic              tx_drive;

  assign tx_start = tx_frame_sync_in & ~tx_fs_d; // R01

  always_comb begin
    next_tx_run  = tx_run;
    next_tx_bit  = tx_bit;
    next_tx_slot = tx_slot;
    if (tx_start) begin
      next_tx_run  = 1'b1;
      next_tx_bit  = '0;
      next_tx_slot = '0;
    end else if (tx_run) begin
      next_tx_bit = tx_bit + 3'h1;
      if (tx_bit == BIT_LAST) begin
        if (tx_slot == SLOT_LAST) begin
          next_tx_run = 1'b0; // R15
        end else begin
          next_tx_slot = tx_slot + 6'h01;
        end
      end
    end
  end

  assign tx_drive = next_tx_run && !pcm_pd &&
                    slot_hit(pcm_delayed, pcm_tx_ts, next_tx_slot);

  always_ff @(posedge pcm_bit_clk_in) begin
    if (pcm_rst) begin
      tx_fs_d <= 1'b0;
      tx_run  <= 1'b0;
      tx_bit  <= '0;
      tx_slot <= '0;
      tx_byte <= 8'h00;
    end else begin
      tx_fs_d <= tx_frame_sync_in;
      tx_run  <= next_tx_run;
      tx_bit  <= next_tx_bit;
      tx_slot <= next_tx_slot;
      if (tx_start) begin
        tx_byte <= pcm_cfg[7:0];
      end
    end
  end

  always_ff @(posedge pcm_bit_clk_in) begin
    if (pcm_rst) begin
      tx_pcm_out              <= 1'b0;
      tx_pcm_oe_n_out         <= 1'b1;
      tx_slot_strobe_n_out    <= 1'b0;
      tx_slot_strobe_oe_n_out <= 1'b1;
    end else begin
      tx_pcm_out <= tx_drive &
                    (tx_start ? pcm_cfg[7] : tx_byte[~next_tx_bit]);
      tx_pcm_oe_n_out         <= ~tx_drive; // R05
      tx_slot_strobe_n_out    <= 1'b0;
      tx_slot_strobe_oe_n_out <= ~tx_drive; // R06
    end
  end

  // Receive slot timing on rising bit clock
  logic              rx_fs_d;
  logic              rx_run;
  logic              rx_active;
  logic [BIT_W-1:0]  rx_bit;
  logic [SLOT_W-1:0] rx_slot;
  logic              next_rx_run;
  logic [BIT_W-1:0]  next_rx_bit;
  logic [SLOT_W-1:0] next_rx_slot;
  logic              rx_start;

  assign rx_start = rx_frame_sync_in & ~rx_fs_d; // R02

  always_comb begin
    next_rx_run  = rx_run;
    next_rx_bit  = rx_bit;
    next_rx_slot = rx_slot;
    if (rx_start) begin
      next_rx_run  = 1'b1;
      next_rx_bit  = '0;
      next_rx_slot = '0;
    end else if (rx_run) begin
      next_rx_bit = rx_bit + 3'h1;
      if (rx_bit == BIT_LAST) begin
        if (rx_slot == SLOT_LAST) begin
          next_rx_run = 1'b0; // R15
        end else begin
          next_rx_slot = rx_slot + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge pcm_bit_clk_in) begin
    if (pcm_rst) begin
      rx_fs_d   <= 1'b0;
      rx_run    <= 1'b0;
      rx_bit    <= '0;
      rx_slot   <= '0;
      rx_active <= 1'b0;
    end else begin
      rx_fs_d   <= rx_frame_sync_in;
      rx_run    <= next_rx_run;
      rx_bit    <= next_rx_bit;
      rx_slot   <= next_rx_slot;
      rx_active <= next_rx_run && !pcm_pd &&
                   slot_hit(pcm_delayed, pcm_rx_ts, next_rx_slot);
    end
  end

  // Receive sampling on falling bit clock
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic       rx_tog;

  always_ff @(negedge pcm_bit_clk_in) begin
    if (pcm_rst) begin
      rx_sh   <= 8'h00;
      rx_byte <= 8'h00;
      rx_tog  <= 1'b0;
    end else if (rx_active) begin
      rx_sh <= {rx_sh[6:0], rx_pcm_in}; // R07
      if (rx_bit == BIT_LAST) begin
        rx_byte <= {rx_sh[6:0], rx_pcm_in};
        rx_tog  <= ~rx_tog;
      end
    end
  end

  // ==========================================================
  // Returns to the core domain
  logic rx_tog_s;
  logic rx_tog_d;

  pcd_sync #(.W(2)) u_core_sync (
    .clk_in (core_clk_in),
    .d_in   ({cfg_ack, rx_tog}),
    .q_out  ({cfg_ack_s, rx_tog_s})
  );

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_tog_d         <= 1'b0;
      rx_pcm_byte_out  <= 8'h00;
      rx_pcm_valid_out <= 1'b0;
    end else begin
      rx_tog_d         <= rx_tog_s;
      rx_pcm_valid_out <= rx_tog_s != rx_tog_d;
      if (rx_tog_s != rx_tog_d) begin
        rx_pcm_byte_out <= rx_byte;
      end
    end
  end

endmodule

// >>> src/pcd_pkg.sv
// Notes on behaviour
// R01 - Transmit frame sync marks slot or frame
// R02 - Receive frame sync marks slot or frame
// R03 - Bit clock from outside shifts data
// R04 - Master clock comes from outside
// R05 - Transmit data driven only in slot
// R06 - Slot strobe pulled low only in slot
// R07 - Receive data sampled only in slot
// R08 - Control shifts only while select low
// R09 - First byte written; bit 2 sets direction
// R10 - Control output driven only during reads
// R11 - Host holds select low whole transfer
// R12 - Four latch pins, direction per bit
// R13 - Input latches captured on control write
// R14 - Output latches show written value
// R15 - Slots assignable within 64-slot frames
// R16 - Gains 25.4 dB range, 0.1 dB steps
// R17 - A-law or mu-law selectable
// R18 - Control bytes shift bit 7 first
// R19 - Bit 7 of byte one controls power
// R20 - Host uses only defined address codes
// R21 - Select high discards partial byte
// R22 - Control output floats when not reading
package pcd_pkg;

  localparam int BYTE_W  = 8;
  localparam int LATCH_N = 4;
  localparam int SLOT_W  = 6;
  localparam int BIT_W   = 3;
  localparam int CFG_W   = 24;

  // First control byte layout
  localparam int CMD_PWR_BIT = 7;
  localparam int ADDR_HI     = 6;
  localparam int ADDR_LO     = 3;
  localparam int CMD_RD_BIT  = 2;
  localparam int CMD_2B_BIT  = 1;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ILR  = 4'h1;
  localparam logic [3:0] ADDR_LDR  = 4'h2;
  localparam logic [3:0] ADDR_RXG  = 4'h4;
  localparam logic [3:0] ADDR_TXG  = 4'h5;
  localparam logic [3:0] ADDR_RXTS = 4'h9;
  localparam logic [3:0] ADDR_TXTS = 4'ha;

  localparam int CTRL_DELAY_BIT = 3;
  localparam int CTRL_LAW_BIT   = 5;
  localparam int SLOT_EN_BIT    = 6;

  localparam int GAIN_RANGE_CDB = 2540;
  localparam int GAIN_STEP_CDB  = 10;
  localparam logic [7:0] GAIN_MAX = 8'(GAIN_RANGE_CDB / GAIN_STEP_CDB);

  localparam logic [SLOT_W-1:0] SLOT_LAST = 6'h3f;
  localparam logic [BIT_W-1:0]  BIT_LAST  = 3'h7;

  localparam int CORE_CLK_NS     = 100;
  localparam int MCLK_TIMEOUT_NS = 4000;
  localparam logic [7:0] MCLK_TO_CYC =
    8'(MCLK_TIMEOUT_NS / CORE_CLK_NS);

  localparam logic [7:0]         RST_CTRL = 8'h00;
  localparam logic [7:0]         RST_GAIN = 8'h00;
  localparam logic [7:0]         RST_SLOT = 8'h00;
  localparam logic [LATCH_N-1:0] RST_LDR  = 4'h0;
  localparam logic [LATCH_N-1:0] RST_ILR  = 4'h0;

endpackage

// >>> src/pcd_sync.sv
module pcd_sync
  import pcd_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge clk_in) begin
    stage1 <= d_in;
    q_out  <= stage1;
  end

endmodule

// >>> src/pcd_ctrl_shift.sv
module pcd_ctrl_shift
  import pcd_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        sdi_in,
  input  wire logic [7:0]  rd_data_in,
  output logic             cmd_done_out,
  output logic             wr_done_out,
  output logic [7:0]       cmd_out,
  output logic [7:0]       wr_data_out,
  output logic             sdo_out,
  output logic             sdo_oe_n_out
);

  logic             sclk_d;
  logic [BIT_W-1:0] cnt;
  logic             second;
  logic             rd_mode;
  logic             loaded;
  logic [7:0]       in_sh;
  logic [7:0]       out_sh;
  logic             rise;
  logic             fall;

  assign rise = sclk_in & ~sclk_d;
  assign fall = ~sclk_in & sclk_d;

  always_ff @(posedge clk_in) begin
    // Tracks the pin through reset, so no false edge on release
    sclk_d <= sclk_in;
  end

  // ==========================================================
  // Input shifting, sampled on falling control clock
  always_ff @(posedge clk_in) begin
    cmd_done_out <= 1'b0;
    wr_done_out  <= 1'b0;
    if (rst_in || cs_n_in) begin // R08 R21
      cnt     <= '0;
      second  <= 1'b0;
      rd_mode <= 1'b0;
      in_sh   <= '0;
    end else if (fall) begin
      in_sh <= {in_sh[6:0], sdi_in}; // R18
      cnt   <= cnt + 3'h1;
      if (cnt == BIT_LAST) begin
        if (!second) begin
          cmd_out      <= {in_sh[6:0], sdi_in}; // R09
          cmd_done_out <= 1'b1;
          second       <= in_sh[CMD_2B_BIT-1];
          rd_mode      <= in_sh[CMD_2B_BIT-1] & in_sh[CMD_RD_BIT-1]; // R09
        end else begin
          if (!rd_mode) begin
            wr_data_out <= {in_sh[6:0], sdi_in};
            wr_done_out <= 1'b1;
          end
          second  <= 1'b0;
          rd_mode <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Read-back shifting on rising control clock
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_n_in) begin // R22
      loaded  <= 1'b0;
      out_sh  <= '0;
      sdo_out <= 1'b0;
    end else if (!rd_mode) begin
      loaded <= 1'b0;
    end else if (rise) begin
      if (!loaded) begin
        sdo_out <= rd_data_in[7]; // R18
        out_sh  <= {rd_data_in[6:0], 1'b0};
        loaded  <= 1'b1;
      end else begin
        sdo_out <= out_sh[7];
        out_sh  <= {out_sh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    sdo_oe_n_out <= rst_in | cs_n_in | ~rd_mode; // R10 R22
  end

endmodule

// >>> verification/pcd_top_properties.sv
module pcd_top_properties
  import pcd_pkg::*;
(
  input wire logic               core_clk_in,
  input wire logic               rst_in,
  input wire logic               pcm_bit_clk_in,
  input wire logic               ctrl_cs_n_in,
  input wire logic               tx_pcm_oe_n_out,
  input wire logic               tx_slot_strobe_n_out,
  input wire logic               tx_slot_strobe_oe_n_out,
  input wire logic [7:0]         rx_pcm_byte_out,
  input wire logic               rx_pcm_valid_out,
  input wire logic               ctrl_data_oe_n_out,
  input wire logic [LATCH_N-1:0] latch_pins_oe_n_out,
  input wire logic               power_down_out,
  input wire logic [7:0]         tx_gain_out,
  input wire logic [7:0]         rx_gain_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // PCM side
  a_strobe_track: assert property (@(posedge pcm_bit_clk_in)
    disable iff (rst_in) tx_slot_strobe_oe_n_out == tx_pcm_oe_n_out)
    else $error("strobe enable differs from data enable");
  a_strobe_level: assert property (@(posedge core_clk_in)
    disable iff (rst_in) !tx_slot_strobe_n_out)
    else $error("strobe level not low");
  a_slot_eight: assert property (@(posedge pcm_bit_clk_in)
    disable iff (rst_in)
    $fell(tx_pcm_oe_n_out) |-> !tx_pcm_oe_n_out [*8] ##1 tx_pcm_oe_n_out)
    else $error("transmit slot not eight bits long");
  a_pd_silent: assert property (@(posedge pcm_bit_clk_in)
    disable iff (rst_in) $fell(tx_pcm_oe_n_out) |-> !power_down_out)
    else $error("transmit driven while powered down");
  a_rx_pulse: assert property (@(posedge core_clk_in)
    disable iff (rst_in) rx_pcm_valid_out |=> !rx_pcm_valid_out)
    else $error("receive valid longer than one cycle");
  a_rx_update: assert property (@(posedge core_clk_in)
    disable iff (rst_in) $changed(rx_pcm_byte_out) |->
    (##[0:1] rx_pcm_valid_out) or $past(rx_pcm_valid_out))
    else $error("receive byte changed without valid");
  // ==========
  // Control side
  a_ctrl_float: assert property (@(posedge core_clk_in)
    disable iff (rst_in) ctrl_cs_n_in [*5] |-> ctrl_data_oe_n_out)
    else $error("control output driven without select");
  a_gain_clamp: assert property (@(posedge core_clk_in)
    disable iff (rst_in) tx_gain_out <= GAIN_MAX && rx_gain_out <= GAIN_MAX)
    else $error("gain beyond range");
  a_quiet_hold: assert property (@(posedge core_clk_in)
    disable iff (rst_in) ctrl_cs_n_in [*6] |=> $stable({power_down_out,
    tx_gain_out, rx_gain_out, latch_pins_oe_n_out}))
    else $error("settings changed without select");
  c_tx_slot: cover property (@(posedge pcm_bit_clk_in)
    $fell(tx_pcm_oe_n_out));
  c_rx_valid: cover property (@(posedge core_clk_in) rx_pcm_valid_out);
  c_ctrl_read: cover property (@(posedge core_clk_in)
    !ctrl_data_oe_n_out);
endmodule

bind pcd_top pcd_top_properties pcd_top_properties_i (.*);

// >>> verification/pcd_highway_model.sv
module pcd_highway_model
  import pcd_pkg::*;
(
  output logic pcm_bit_clk_out,
  output logic master_clk_out,
  output logic tx_frame_sync_out,
  output logic rx_frame_sync_out,
  output logic rx_pcm_out,
  input  wire logic tx_pcm_in,
  input  wire logic tx_pcm_oe_n_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_seen;
  int         tx_bits;
  initial begin
    pcm_bit_clk_out = 1'b0;
    tx_frame_sync_out = 1'b0;
    rx_frame_sync_out = 1'b0;
    rx_pcm_out = 1'b0;
  end
  // Bit clock runs free, master clock locked to it
  always #24 pcm_bit_clk_out = ~pcm_bit_clk_out;
  assign master_clk_out = pcm_bit_clk_out;
  // One 64-slot frame, receive byte placed in slot rs
  task automatic frame(input logic [5:0] rs, input logic [7:0] rb);
    int e;
    tx_seen = 8'h00;
    tx_bits = 0;
    @(negedge pcm_bit_clk_out);
    tx_frame_sync_out = 1'b1;
    rx_frame_sync_out = 1'b1;
    for (e = 0; e < 512; e++) begin
      @(posedge pcm_bit_clk_out);
      #2;
      tx_frame_sync_out = 1'b0;
      rx_frame_sync_out = 1'b0;
      // Outside the slot the line toggles
      rx_pcm_out = (e / 8 == rs) ? rb[7 - e % 8] : ~rx_pcm_out;
      @(negedge pcm_bit_clk_out);
      if (tx_pcm_oe_n_in === 1'b0) begin
        tx_seen = {tx_seen[6:0], tx_pcm_in};
        tx_bits++;
      end
    end
  endtask
endmodule

// >>> verification/pcd_top_test.sv
module pcd_top_test
  import pcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  failures++; $display("ERROR %s expected %h seen %h", n, e, s); end end

  logic               core_clk_in = 1'b0;
  logic               rst_in      = 1'b1;
  logic               ctrl_clock        = 1'b1;
  logic               cs_n        = 1'b1;
  logic               cdi         = 1'b0;
  logic [7:0]         txb         = 8'ha5;
  logic [LATCH_N-1:0] pin_drv     = 4'h0;
  logic [7:0]         rd, rb;
  logic [5:0]         sl;
  int                 failures    = 0;
  int                 checked     = 0;
  int                 k;
  wire [LATCH_N-1:0]  pins, lat_out, lat_oe_n;
  wire [7:0]          txg, rxg, rxbyte;
  wire                bclk, mclk, tx_frame_sync, rx_frame_sync, rxd, txd, tx_oe_n;
  wire                cdo, cdo_oe_n, pd, alaw, dly, mact;

  // Pin level from both drivers
  assign pins = (lat_oe_n & pin_drv) | (~lat_oe_n & lat_out);
  always #50 core_clk_in = ~core_clk_in;

  pcd_top pcd_top_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in),
    .pcm_bit_clk_in(bclk), .master_clk_in(mclk),
    .tx_frame_sync_in(tx_frame_sync), .rx_frame_sync_in(rx_frame_sync),
    .rx_pcm_in(rxd), .tx_pcm_byte_in(txb),
    .ctrl_clock_in(ctrl_clock), .ctrl_cs_n_in(cs_n),
    .ctrl_data_in(cdi), .latch_pins_in(pins),
    .tx_pcm_out(txd), .tx_pcm_oe_n_out(tx_oe_n),
    .tx_slot_strobe_n_out(), .tx_slot_strobe_oe_n_out(),
    .rx_pcm_byte_out(rxbyte), .rx_pcm_valid_out(),
    .ctrl_data_out(cdo), .ctrl_data_oe_n_out(cdo_oe_n),
    .latch_pins_out(lat_out), .latch_pins_oe_n_out(lat_oe_n),
    .power_down_out(pd), .a_law_out(alaw),
    .delayed_mode_out(dly), .tx_gain_out(txg),
    .rx_gain_out(rxg), .mclk_active_out(mact)
  );
  pcd_highway_model pcd_highway_model_i (
    .pcm_bit_clk_out(bclk), .master_clk_out(mclk),
    .tx_frame_sync_out(tx_frame_sync), .rx_frame_sync_out(rx_frame_sync),
    .rx_pcm_out(rxd), .tx_pcm_in(txd), .tx_pcm_oe_n_in(tx_oe_n)
  );

  // ==========
  // Control port access
  task step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task bits(input logic [7:0] d, input int n, output logic [7:0] q);
    int i;
    q = 8'h00;
    for (i = 7; i > 7 - n; i--) begin
      ctrl_clock = 1'b1;
      cdi = d[i];
      step(6);
      q[i] = cdo;
      ctrl_clock = 1'b0;
      step(6);
    end
    ctrl_clock = 1'b1;
  endtask
  task xfer(input logic [7:0] b1, b2, output logic [7:0] q);
    logic [7:0] d;
    q = 8'h00;
    cs_n = 1'b0;
    step(2);
    bits(b1, 8, d);
    if (b1[CMD_2B_BIT]) bits(b2, 8, q);
    step(6);
    cs_n = 1'b1;
    step(8);
  endtask
  task results;
    $display("Checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========
  // Main sequence
  initial begin
    step(4);
    rst_in = 1'b0;
    step(1);
    `CHK("power_down", 1'b1, pd)
    `CHK("latch_oe_n", 4'hf, lat_oe_n)
    `CHK("ctrl_oe_n", 1'b1, cdo_oe_n)
    step(4);
    xfer(8'h02, 8'h28, rd);
    `CHK("power_down", 1'b0, pd)
    `CHK("a_law", 1'b1, alaw)
    `CHK("delayed", 1'b1, dly)
    `CHK("mclk_active", 1'b1, mact)
    xfer(8'h06, 8'h00, rd);
    `CHK("ctrl_read", 8'h28, rd)
    // Aborted byte must leave no trace
    cs_n = 1'b0;
    step(2);
    bits(8'hff, 3, rd);
    cs_n = 1'b1;
    step(8);
    xfer(8'h2a, 8'hff, rd);
    `CHK("tx_gain", GAIN_MAX, txg)
    xfer(8'h22, 8'h7b, rd);
    `CHK("rx_gain", 8'h7b, rxg)
    xfer(8'h26, 8'h00, rd);
    `CHK("rx_gain_read", 8'h7b, rd)
    xfer(8'h1a, 8'h55, rd);
    xfer(8'h1e, 8'h00, rd);
    `CHK("bad_addr_read", 8'h00, rd)
    `CHK("rx_gain_kept", 8'h7b, rxg)
    xfer(8'h12, 8'h05, rd);
    `CHK("latch_oe_n", 4'ha, lat_oe_n)
    xfer(8'h0a, 8'h0f, rd);
    `CHK("latch_out", 4'h5, lat_out & 4'h5)
    for (k = 0; k < 2; k++) begin
      pin_drv = k ? 4'ha : 4'h0;
      step(4);
      xfer(8'h0e, 8'h00, rd);
      `CHK("latch_in", pin_drv & 4'ha, rd[3:0] & 4'ha)
    end
    // Slot 3 and 63 delayed, then non-delayed slot 0
    for (k = 0; k < 3; k++) begin
      sl = (k == 0) ? 6'h03 : 6'h3f;
      rb = {4'h6, 4'(k)};
      xfer(8'h02, (k == 2) ? 8'h20 : 8'h28, rd);
      xfer(8'h52, {2'h1, sl}, rd);
      xfer(8'h4a, {2'h1, sl}, rd);
      step(20);
      `CHK("delayed_mode", (k != 2), dly)
      pcd_highway_model_i.frame((k == 2) ? 6'h00 : sl, rb);
      step(10);
      `CHK("tx_byte", txb, pcd_highway_model_i.tx_seen)
      `CHK("tx_bits", 8, pcd_highway_model_i.tx_bits)
      `CHK("rx_byte", rb, rxbyte)
    end
    xfer(8'h80, 8'h00, rd);
    `CHK("power_down", 1'b1, pd)
    step(20);
    pcd_highway_model_i.frame(6'h00, 8'h00);
    `CHK("tx_bits_pd", 0, pcd_highway_model_i.tx_bits)
    results;
  end
endmodule
